// ===== cfg_sup_params.svh
// Constants for the configuration and fault supervisor: addresses, limits, counts.
// Included by the package and by every design file; definitions only.
`ifndef CFG_SUP_PARAMS_SVH
`define CFG_SUP_PARAMS_SVH
`define GLOBAL_ADDR_A 7'h5A
`define GLOBAL_ADDR_B 7'h5B
`define RECOVERY_ADDR 7'h7C
`define IGNORE_PINS_BIT 6
`define TEMP_HOT_C 16'sh0082
`define TEMP_COOL_C 16'sh007D
`define CRC_POLY 16'h1021
`define CRC_INIT 16'hFFFF
`define NVM_WORDS 16
`define MON_CYCLE_MS 90
`define CLK_KHZ 40000
`define MON_CYCLES (`MON_CYCLE_MS * `CLK_KHZ)
`define OVF_NUM 11'h06E
`define OVW_FINE 11'h433
`define MRH_NUM 11'h069
`define MRL_NUM 11'h05F
`define UVF_NUM 11'h05D
`define UVF_FINE 11'h3A2
`define UVW_FINE 11'h3A7
`define LIM_DEN 11'h064
`define FINE_DEN 11'h3E8
`endif

// ===== cfg_sup_pkg.sv
// Types shared by the supervisor files.
// Assumes cfg_sup_params.svh lies in the include path.
`include "cfg_sup_params.svh"
package cfg_sup_pkg;
    typedef struct packed {
        logic [15:0] vout;
        logic [2:0] rate;
        logic [2:0] phase;
        logic sync_drive;
    } chan_cfg_s;
    typedef struct packed {
        logic [15:0] ov_fault;
        logic [15:0] ov_warn;
        logic [15:0] vmax;
        logic [15:0] margin_hi;
        logic [15:0] margin_lo;
        logic [15:0] uv_warn;
        logic [15:0] uv_fault;
    } limits_s;
    typedef enum logic [3:0] {
        LD_IDLE = 4'h1,
        LD_CRC = 4'h2,
        LD_APPLY = 4'h4,
        LD_FAIL = 4'h8
    } load_e;
endpackage : cfg_sup_pkg

// ===== vout_limits.sv
// Derives voltage limits as fixed percentages of a pin-selected output voltage.
// Assumes a registered voltage code at its input; output registered.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_sup_params.svh"
module vout_limits (
    input wire logic CLK, // clock
    input wire logic RST, // sync reset
    input wire logic [15:0] vout, // selected voltage code
    output cfg_sup_pkg::limits_s lim // derived limits
);
    function automatic logic [15:0] pct(input logic [15:0] v, input logic [10:0] num);
        logic [26:0] p;
        p = v * num;
        pct = 16'(p / `LIM_DEN);
    endfunction : pct
    function automatic logic [15:0] permil(input logic [15:0] v, input logic [10:0] num);
        logic [26:0] p;
        p = v * num;
        permil = 16'(p / `FINE_DEN);
    endfunction : permil
    cfg_sup_pkg::limits_s next_lim;
    always_comb begin
        next_lim.ov_fault = pct(vout, `OVF_NUM);
        next_lim.ov_warn = permil(vout, `OVW_FINE);
        next_lim.vmax = permil(vout, `OVW_FINE);
        next_lim.margin_hi = pct(vout, `MRH_NUM);
        next_lim.margin_lo = pct(vout, `MRL_NUM);
        next_lim.uv_warn = permil(vout, `UVW_FINE);
        next_lim.uv_fault = permil(vout, `UVF_FINE);
    end
    always_ff @(posedge CLK) begin
        if (RST) begin
            lim <= '0;
        end else begin
            lim <= next_lim;
        end
    end
endmodule : vout_limits
`default_nettype wire

// ===== nvm_crc.sv
// Walks the stored configuration words and checks them against a stored CRC.
// Assumes memory words are presented by index and stable during a check.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_sup_params.svh"
module nvm_crc #(
    parameter int WORDS = `NVM_WORDS
) (
    input wire logic CLK, // clock
    input wire logic RST, // sync reset
    input wire logic start, // one-cycle start
    input wire logic [15:0] word, // word at index
    input wire logic [15:0] expect_crc, // stored CRC
    output logic [$clog2(WORDS)-1:0] index, // word index
    output logic done, // one-cycle finish
    output logic ok // CRC matched at done
);
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 15; i >= 0; i--) begin
            r = (r[15] ^ d[i]) ? ((r << 1) ^ `CRC_POLY) : (r << 1);
        end
        crc_step = r;
    endfunction : crc_step
    logic busy, next_busy, next_done, next_ok;
    logic [15:0] crc, next_crc;
    logic [$clog2(WORDS)-1:0] next_index;
    always_comb begin
        next_busy = busy;
        next_crc = crc;
        next_index = index;
        next_done = 1'b0;
        next_ok = ok;
        if (start) begin
            next_busy = 1'b1;
            next_crc = `CRC_INIT;
            next_index = '0;
        end else if (busy) begin
            next_crc = crc_step(crc, word);
            next_index = index + 1'b1;
            if (index == $clog2(WORDS)'(WORDS - 1)) begin
                next_busy = 1'b0;
                next_done = 1'b1;
                next_ok = (crc_step(crc, word) == expect_crc);
            end
        end
    end
    always_ff @(posedge CLK) begin
        if (RST) begin
            busy <= 1'b0;
            crc <= `CRC_INIT;
            index <= '0;
            done <= 1'b0;
            ok <= 1'b0;
        end else begin
            busy <= next_busy;
            crc <= next_crc;
            index <= next_index;
            done <= next_done;
            ok <= next_ok;
        end
    end
endmodule : nvm_crc
`default_nettype wire

// ===== cfg_fault_supervisor.sv
// Configuration loading, address resolution, memory gating and output fault supervision.
// Assumes pin codes come from an ADC with a valid strobe per pin, on CLK; bus
// traffic is decoded elsewhere and reported here as strobes.
// How it works
// - Nonzero load slope turns servo off
// - Open pin uses stored memory value
// - Sample pins only at power-up, restore, reset
// - Ignore bit ignores all but address pins
// - Bus writes override pin values except in apply cycle
// - Low pin four bits, high pin three
// - Both pins open: stored address whole
// - Always answer both global addresses
// - Pin voltage derives fixed percentage limits
// - Rate pin sets rate, enables sync
// - CRC-check memory at every load
// - CRC failure: flags, alert low, runs low
// - After CRC failure answer recovery, global only
// - Hot die refuses memory ops except two
// - Input limits judged from monitor conversions
// - Output overvoltage: top off, bottom on
// - Mask undervoltage until channel fully started
// - No switching action on undervoltage
`timescale 1ns/1ps
`default_nettype none
`include "cfg_sup_params.svh"
module cfg_fault_supervisor (
    input wire logic CLK, // 40 MHz clock
    input wire logic RST, // sync reset, high
    input wire logic POWER_UP, // power-up sample pulse
    input wire logic RESTORE_CMD, // restore-from-memory pulse
    input wire logic VENDOR_RESET_CMD, // vendor_reset_command pulse
    input wire logic NVM_OP_REQ, // other memory op pulse
    input wire logic [5:0] PIN_OPEN, // per-pin open flags
    input wire logic [5:0] PIN_GND, // per-pin grounded flags
    input wire logic [3:0] ADDR_LOW_CODE, // addr_low_select_pin code
    input wire logic [2:0] ADDR_HIGH_CODE, // addr_high_select_pin code
    input wire logic [15:0] OUT0_VCODE, // out0_voltage_cfg_pin code
    input wire logic [15:0] OUT1_VCODE, // out1_voltage_cfg_pin code
    input wire logic [2:0] RATE_CODE, // switch_rate_cfg_pin code
    input wire logic [2:0] PHASE_CODE, // phase_cfg_pin code
    input wire logic [6:0] STORED_ADDR, // stored_bus_address
    input wire logic [7:0] GLOBAL_CFG, // global_config_setting
    input wire logic [15:0] NVM_WORD, // memory word at index
    input wire logic [15:0] NVM_CRC, // stored CRC
    input wire logic [15:0] NVM_VOUT0, // stored channel 0 voltage
    input wire logic [15:0] NVM_VOUT1, // stored channel 1 voltage
    input wire logic [2:0] NVM_RATE, // stored rate
    input wire logic [2:0] NVM_PHASE, // stored phase
    input wire logic NVM_SYNC, // stored sync drive
    input wire logic BUS_WR_VOUT0, // bus write voltage 0
    input wire logic BUS_WR_VOUT1, // bus write voltage 1
    input wire logic BUS_WR_RATE, // bus write rate
    input wire logic [15:0] BUS_WDATA, // bus write data
    input wire logic [6:0] BUS_ADDR, // addressed byte on bus
    input wire logic [1:0][15:0] LOAD_SLOPE, // load_slope_setting per channel
    input wire logic signed [15:0] DIE_TEMP, // die temperature, degrees
    input wire logic MON_VALID, // monitor conversion strobe
    input wire logic VIN_UV_MON, // input UV from monitor
    input wire logic VIN_OV_MON, // input OV from monitor
    input wire logic [1:0] OV_CMP, // output OV comparators
    input wire logic [1:0] UV_CMP, // output UV comparators
    input wire logic [1:0] UV_WARN_MON, // output UV warn monitor
    input wire logic [1:0] REV_OC, // reverse overcurrent
    input wire logic PROTOCOL0, // control protocol 0
    input wire logic [1:0] CH_ON, // channel commanded on
    input wire logic [1:0] START_DONE, // delay, ramp, max time done
    input wire logic [1:0] OC_HIT, // overcurrent limit reached
    input wire logic [1:0] FALLING, // turn-off fall active
    output logic ADDR_MATCH, // bus address answered
    output logic [6:0] DEV_ADDR, // resolved address
    output logic SERVO_EN0, // channel 0 servo on
    output logic SERVO_EN1, // channel 1 servo on
    output cfg_sup_pkg::chan_cfg_s CFG0, // channel 0 working cfg
    output cfg_sup_pkg::chan_cfg_s CFG1, // channel 1 working cfg
    output cfg_sup_pkg::limits_s LIM0, // channel 0 limits
    output cfg_sup_pkg::limits_s LIM1, // channel 1 limits
    output logic CML_STATUS, // CML summary bit
    output logic CRC_ERR_FLAG, // vendor_status_flags CRC bit
    output logic ALERT_N, // alert line, low active
    output logic [1:0] RUN_FORCE_LOW, // run lines pulled low
    output logic NVM_REFUSE, // memory op refused pulse
    output logic NVM_GRANT, // memory op granted pulse
    output logic VIN_UV, // input UV status
    output logic VIN_OV, // input OV status
    output logic [1:0] TOP_OFF, // high-side forced off
    output logic [1:0] BOT_ON, // low-side forced on
    output logic [1:0] UV_FAULT, // masked UV fault
    output logic [1:0] UV_WARN // masked UV warning
);
    localparam int PA_LO = 0;
    localparam int PA_HI = 1;
    localparam int PV0 = 2;
    localparam int PV1 = 3;
    localparam int PRATE = 4;
    localparam int PPH = 5;

    cfg_sup_pkg::load_e st, next_st;
    logic [4:0] sync1, sync2;
    logic sample_req, crc_done, crc_ok, crc_start, crc_fail, next_crc_fail;
    logic hot, next_hot, ignore_pins;
    logic [6:0] next_addr;
    cfg_sup_pkg::chan_cfg_s next_cfg0, next_cfg1;
    logic [15:0] lim_src0, lim_src1;
    logic [1:0] pin_volt, next_pin_volt;

    // Pin-side strobes cross in from outside, so they pass two stages
    always_ff @(posedge CLK) begin
        if (RST) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {POWER_UP, RESTORE_CMD, VENDOR_RESET_CMD, NVM_OP_REQ, MON_VALID};
            sync2 <= sync1;
        end
    end
    assign sample_req = sync2[4] | sync2[3] | sync2[2];
    assign ignore_pins = GLOBAL_CFG[`IGNORE_PINS_BIT];

    // Loader: sample request starts CRC; configuration applied on pass
    always_comb begin
        next_st = st;
        crc_start = 1'b0;
        next_crc_fail = crc_fail;
        unique case (st)
            cfg_sup_pkg::LD_IDLE: begin
                if (sample_req) begin
                    crc_start = 1'b1;
                    next_st = cfg_sup_pkg::LD_CRC;
                end
            end
            cfg_sup_pkg::LD_CRC: begin
                if (crc_done) begin
                    next_st = crc_ok ? cfg_sup_pkg::LD_APPLY : cfg_sup_pkg::LD_FAIL;
                    next_crc_fail = !crc_ok;
                end
            end
            cfg_sup_pkg::LD_APPLY: next_st = cfg_sup_pkg::LD_IDLE;
            cfg_sup_pkg::LD_FAIL: begin
                if (sample_req) begin
                    crc_start = 1'b1;
                    next_st = cfg_sup_pkg::LD_CRC;
                end
            end
        endcase
    end

    nvm_crc #(.WORDS(`NVM_WORDS)) u_crc (
        .CLK(CLK),
        .RST(RST),
        .start(crc_start),
        .word(NVM_WORD),
        .expect_crc(NVM_CRC),
        .index(),
        .done(crc_done),
        .ok(crc_ok)
    );

    // Working parameter set: pin values latched only at apply, bus writes win after
    always_comb begin
        next_addr = DEV_ADDR;
        next_cfg0 = CFG0;
        next_cfg1 = CFG1;
        next_pin_volt = pin_volt;
        if (st == cfg_sup_pkg::LD_APPLY) begin
            next_addr[3:0] = PIN_OPEN[PA_LO] ? STORED_ADDR[3:0] : ADDR_LOW_CODE;
            next_addr[6:4] = PIN_OPEN[PA_HI] ? STORED_ADDR[6:4] : ADDR_HIGH_CODE;
            next_pin_volt[0] = !(PIN_OPEN[PV0] | ignore_pins);
            next_pin_volt[1] = !(PIN_OPEN[PV1] | ignore_pins);
            next_cfg0.vout = next_pin_volt[0] ? OUT0_VCODE : NVM_VOUT0;
            next_cfg1.vout = next_pin_volt[1] ? OUT1_VCODE : NVM_VOUT1;
            if (PIN_OPEN[PRATE] | PIN_GND[PRATE] | ignore_pins) begin
                next_cfg0.rate = NVM_RATE;
                next_cfg0.sync_drive = NVM_SYNC;
            end else begin
                next_cfg0.rate = RATE_CODE;
                next_cfg0.sync_drive = 1'b1;
            end
            next_cfg0.phase = (PIN_OPEN[PPH] | ignore_pins) ? NVM_PHASE : PHASE_CODE;
            next_cfg1.rate = next_cfg0.rate;
            next_cfg1.phase = next_cfg0.phase;
            next_cfg1.sync_drive = next_cfg0.sync_drive;
        end else begin
            if (BUS_WR_VOUT0) begin
                next_cfg0.vout = BUS_WDATA;
                next_pin_volt[0] = 1'b0;
            end
            if (BUS_WR_VOUT1) begin
                next_cfg1.vout = BUS_WDATA;
                next_pin_volt[1] = 1'b0;
            end
            if (BUS_WR_RATE) begin
                next_cfg0.rate = BUS_WDATA[2:0];
                next_cfg1.rate = BUS_WDATA[2:0];
            end
        end
    end

    // Limits only follow a pin-derived voltage; otherwise they are derived from zero
    assign lim_src0 = pin_volt[0] ? CFG0.vout : '0;
    assign lim_src1 = pin_volt[1] ? CFG1.vout : '0;
    vout_limits u_lim0 (.CLK(CLK), .RST(RST), .vout(lim_src0), .lim(LIM0));
    vout_limits u_lim1 (.CLK(CLK), .RST(RST), .vout(lim_src1), .lim(LIM1));

    // Die temperature hysteresis for memory gating
    always_comb begin
        next_hot = hot;
        if (DIE_TEMP > `TEMP_HOT_C) begin
            next_hot = 1'b1;
        end else if (DIE_TEMP < `TEMP_COOL_C) begin
            next_hot = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st <= cfg_sup_pkg::LD_IDLE;
            crc_fail <= 1'b0;
            hot <= 1'b0;
            DEV_ADDR <= '0;
            CFG0 <= '0;
            CFG1 <= '0;
            pin_volt <= '0;
        end else begin
            st <= next_st;
            crc_fail <= next_crc_fail;
            hot <= next_hot;
            DEV_ADDR <= next_addr;
            CFG0 <= next_cfg0;
            CFG1 <= next_cfg1;
            pin_volt <= next_pin_volt;
        end
    end

    // Status, address answer, memory gating and output supervision
    always_ff @(posedge CLK) begin
        if (RST) begin
            ADDR_MATCH <= 1'b0;
            SERVO_EN0 <= 1'b1;
            SERVO_EN1 <= 1'b1;
            CML_STATUS <= 1'b0;
            CRC_ERR_FLAG <= 1'b0;
            ALERT_N <= 1'b1;
            RUN_FORCE_LOW <= '0;
            NVM_REFUSE <= 1'b0;
            NVM_GRANT <= 1'b0;
            VIN_UV <= 1'b0;
            VIN_OV <= 1'b0;
            TOP_OFF <= '0;
            BOT_ON <= '0;
            UV_FAULT <= '0;
            UV_WARN <= '0;
        end else begin
            ADDR_MATCH <= (BUS_ADDR == `GLOBAL_ADDR_A) || (BUS_ADDR == `GLOBAL_ADDR_B)
                || (crc_fail ? (BUS_ADDR == `RECOVERY_ADDR) : (BUS_ADDR == DEV_ADDR));
            SERVO_EN0 <= (LOAD_SLOPE[0] == '0);
            SERVO_EN1 <= (LOAD_SLOPE[1] == '0);
            CML_STATUS <= crc_fail;
            CRC_ERR_FLAG <= crc_fail;
            ALERT_N <= !crc_fail;
            RUN_FORCE_LOW <= {2{crc_fail}};
            NVM_REFUSE <= sync2[1] & hot;
            NVM_GRANT <= sync2[1] & !hot;
            if (sync2[0]) begin
                VIN_UV <= VIN_UV_MON;
                VIN_OV <= VIN_OV_MON;
            end
            for (int c = 0; c < 2; c++) begin
                TOP_OFF[c] <= OV_CMP[c] & !(PROTOCOL0 & REV_OC[c]);
                BOT_ON[c] <= OV_CMP[c] & !(PROTOCOL0 & REV_OC[c]);
                // Status only; switching never reacts to these
                UV_FAULT[c] <= UV_CMP[c] & CH_ON[c] & START_DONE[c]
                    & !OC_HIT[c] & !FALLING[c];
                UV_WARN[c] <= UV_WARN_MON[c] & CH_ON[c] & START_DONE[c]
                    & !OC_HIT[c] & !FALLING[c];
            end
        end
    end

    a_crc_alert: assert property (@(posedge CLK) disable iff (RST)
        (st == cfg_sup_pkg::LD_CRC && crc_done && !crc_ok) |-> ##2 (!ALERT_N && RUN_FORCE_LOW == 2'h3))
        else $error("crc failure did not pull alert and run low");
    a_recovery_addr: assert property (@(posedge CLK) disable iff (RST)
        (crc_fail && BUS_ADDR == DEV_ADDR && DEV_ADDR != `RECOVERY_ADDR
         && DEV_ADDR != `GLOBAL_ADDR_A && DEV_ADDR != `GLOBAL_ADDR_B) |=> !ADDR_MATCH)
        else $error("own address answered during recovery");
    a_global_addr: assert property (@(posedge CLK) disable iff (RST)
        (BUS_ADDR == `GLOBAL_ADDR_A || BUS_ADDR == `GLOBAL_ADDR_B) |=> ADDR_MATCH)
        else $error("global address not answered");
    a_hot_refuse: assert property (@(posedge CLK) disable iff (RST)
        (hot && sync2[1]) |=> (NVM_REFUSE && !NVM_GRANT))
        else $error("memory op granted while hot");
    a_servo_off: assert property (@(posedge CLK) disable iff (RST)
        (LOAD_SLOPE[0] != '0) |=> !SERVO_EN0)
        else $error("servo left on with load slope");
    a_ov_switch: assert property (@(posedge CLK) disable iff (RST)
        (OV_CMP[0] && !REV_OC[0]) |=> (TOP_OFF[0] && BOT_ON[0]))
        else $error("overvoltage did not force switches");
    a_uv_mask: assert property (@(posedge CLK) disable iff (RST)
        (!CH_ON[1] || FALLING[1]) |=> (!UV_FAULT[1] && !UV_WARN[1]))
        else $error("undervoltage not masked");
    a_pin_hold: assert property (@(posedge CLK) disable iff (RST)
        (st != cfg_sup_pkg::LD_APPLY) |=> $stable(DEV_ADDR))
        else $error("address changed outside a sampling event");
    a_addr_split: assert property (@(posedge CLK) disable iff (RST)
        (st == cfg_sup_pkg::LD_APPLY && !PIN_OPEN[PA_LO]) |=> (DEV_ADDR[3:0] == $past(ADDR_LOW_CODE)))
        else $error("low address bits not from pin");
    a_bus_override: assert property (@(posedge CLK) disable iff (RST)
        (BUS_WR_VOUT0 && st != cfg_sup_pkg::LD_APPLY) |=> (CFG0.vout == $past(BUS_WDATA)))
        else $error("bus write did not override voltage");
    c_crc_pass: cover property (@(posedge CLK) disable iff (RST) st == cfg_sup_pkg::LD_APPLY);
    c_crc_fail: cover property (@(posedge CLK) disable iff (RST) st == cfg_sup_pkg::LD_FAIL);
    c_hot_refuse: cover property (@(posedge CLK) disable iff (RST) NVM_REFUSE);
    c_ov_hit: cover property (@(posedge CLK) disable iff (RST) TOP_OFF[0]);
endmodule : cfg_fault_supervisor
`default_nettype wire

// ===== nvm_model.sv
// Stored memory model: every word holds one value, the CRC can be spoiled.
// Assumes the supervisor walks the words by an index it keeps to itself.
`timescale 1ns/1ps
`default_nettype none
module nvm_model (
    input wire logic spoil, // corrupt the stored CRC
    output logic [15:0] word, // word at any index
    output logic [15:0] crc // stored CRC
);
    logic [15:0] c;
    assign word = 16'hA5C3;
    // Same word at every index, so the walk order cannot matter
    always_comb begin
        c = 16'hFFFF;
        for (int w = 0; w < 16; w++)
            for (int b = 15; b >= 0; b--)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ word[b]) ? 16'h1021 : 16'h0000);
        crc = spoil ? ~c : c;
    end
endmodule : nvm_model
`default_nettype wire

// ===== test_cfg_fault_supervisor.sv
// Self-checking bench for the configuration and fault supervisor.
// Assumes the design files and nvm_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_sup_params.svh"
module test_cfg_fault_supervisor;
    logic CLK = 0, RST = 1, POWER_UP = 0, RESTORE_CMD = 0, VENDOR_RESET_CMD = 0;
    logic NVM_OP_REQ = 0, NVM_SYNC = 0, BUS_WR_VOUT0 = 0, BUS_WR_VOUT1 = 0, BUS_WR_RATE = 0;
    logic MON_VALID = 0, VIN_UV_MON = 0, VIN_OV_MON = 0, PROTOCOL0 = 0, spoil = 0;
    logic [5:0] PIN_OPEN = 6'h00, PIN_GND = 6'h00;
    logic [3:0] ADDR_LOW_CODE = 4'h3;
    logic [2:0] ADDR_HIGH_CODE = 3'h5, RATE_CODE = 3'h6, PHASE_CODE = 3'h1;
    logic [2:0] NVM_RATE = 3'h2, NVM_PHASE = 3'h0;
    logic [6:0] STORED_ADDR = 7'h21, BUS_ADDR = 7'h00;
    logic [7:0] GLOBAL_CFG = 8'h00;
    logic [15:0] OUT0_VCODE = 16'h03E8, OUT1_VCODE = 16'h07D0, NVM_WORD, NVM_CRC;
    logic [15:0] NVM_VOUT0 = 16'h0400, NVM_VOUT1 = 16'h0500, BUS_WDATA = 16'h0000;
    logic [1:0][15:0] LOAD_SLOPE = '0;
    logic signed [15:0] DIE_TEMP = 16'sh0019;
    logic [1:0] OV_CMP = 2'h0, UV_CMP = 2'h0, UV_WARN_MON = 2'h0, REV_OC = 2'h0, CH_ON = 2'h0;
    logic [1:0] START_DONE = 2'h0, OC_HIT = 2'h0, FALLING = 2'h0;
    logic ADDR_MATCH, SERVO_EN0, SERVO_EN1, CML_STATUS, CRC_ERR_FLAG, ALERT_N;
    logic NVM_REFUSE, NVM_GRANT, VIN_UV, VIN_OV;
    logic [6:0] DEV_ADDR;
    logic [1:0] RUN_FORCE_LOW, TOP_OFF, BOT_ON, UV_FAULT, UV_WARN;
    cfg_sup_pkg::chan_cfg_s CFG0, CFG1;
    cfg_sup_pkg::limits_s LIM0, LIM1;
    int failures = 0;
    int check_count = 0;
    initial begin
        forever #12.5 CLK = ~CLK;
    end
    nvm_model mem (.spoil(spoil), .word(NVM_WORD), .crc(NVM_CRC));
    cfg_fault_supervisor dut (.CLK, .RST, .POWER_UP, .RESTORE_CMD, .VENDOR_RESET_CMD,
        .NVM_OP_REQ, .PIN_OPEN, .PIN_GND, .ADDR_LOW_CODE, .ADDR_HIGH_CODE, .OUT0_VCODE,
        .OUT1_VCODE, .RATE_CODE, .PHASE_CODE, .STORED_ADDR, .GLOBAL_CFG, .NVM_WORD, .NVM_CRC,
        .NVM_VOUT0, .NVM_VOUT1, .NVM_RATE, .NVM_PHASE, .NVM_SYNC, .BUS_WR_VOUT0, .BUS_WR_VOUT1,
        .BUS_WR_RATE, .BUS_WDATA, .BUS_ADDR, .LOAD_SLOPE, .DIE_TEMP, .MON_VALID, .VIN_UV_MON,
        .VIN_OV_MON, .OV_CMP, .UV_CMP, .UV_WARN_MON, .REV_OC, .PROTOCOL0, .CH_ON, .START_DONE,
        .OC_HIT, .FALLING, .ADDR_MATCH, .DEV_ADDR, .SERVO_EN0, .SERVO_EN1, .CFG0, .CFG1, .LIM0,
        .LIM1, .CML_STATUS, .CRC_ERR_FLAG, .ALERT_N, .RUN_FORCE_LOW, .NVM_REFUSE, .NVM_GRANT,
        .VIN_UV, .VIN_OV, .TOP_OFF, .BOT_ON, .UV_FAULT, .UV_WARN);
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : cyc
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic am(input logic [6:0] a, input logic e);
        @(posedge CLK);
        BUS_ADDR <= a;
        cyc(2);
        chk(ADDR_MATCH, e);
    endtask : am
    // Kind 0 power-up, 1 restore, 2 vendor reset; 30 cycles covers the CRC walk
    task automatic load(input int k);
        @(posedge CLK);
        POWER_UP <= (k == 0);
        RESTORE_CMD <= (k == 1);
        VENDOR_RESET_CMD <= (k == 2);
        @(posedge CLK);
        {POWER_UP, RESTORE_CMD, VENDOR_RESET_CMD} <= 3'h0;
        cyc(30);
    endtask : load
    task automatic memop(input logic e);
        logic r, g;
        r = 1'b0;
        g = 1'b0;
        @(posedge CLK);
        NVM_OP_REQ <= 1'b1;
        @(posedge CLK);
        NVM_OP_REQ <= 1'b0;
        repeat (6) begin
            cyc(1);
            r = r | NVM_REFUSE;
            g = g | NVM_GRANT;
        end
        chk({r, g}, {e, ~e});
    endtask : memop
    task automatic final_report;
        if (failures == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report
    initial begin
        #(3000 * 25);
        failures++;
        final_report();
    end
    initial begin
        repeat (20) @(posedge CLK);
        RST <= 1'b0;
        cyc(1);
        chk({ALERT_N, SERVO_EN0, SERVO_EN1, CRC_ERR_FLAG, RUN_FORCE_LOW}, 16'h0038);
        load(0);
        chk(DEV_ADDR, 16'h0053);
        chk(CFG0.vout, 16'h03E8);
        chk(CFG1.vout, 16'h07D0);
        chk(LIM0.ov_fault, 16'h044C);
        chk(LIM0.ov_warn, 16'h0433);
        chk(LIM0.margin_lo, 16'h03B6);
        chk(LIM0.uv_warn, 16'h03A7);
        chk(LIM0.uv_fault, 16'h03A2);
        chk(LIM1.ov_fault, 16'h0898);
        chk(CFG0.phase, 16'h0001);
        chk({CFG0.rate, CFG0.sync_drive}, 16'h000D);
        chk({CRC_ERR_FLAG, ALERT_N}, 16'h0001);
        am(7'h53, 1'b1);
        am(7'h5A, 1'b1);
        am(7'h5B, 1'b1);
        am(7'h7C, 1'b0);
        @(posedge CLK);
        OUT0_VCODE <= 16'h0123;
        PIN_OPEN <= 6'h07;
        PIN_GND <= 6'h10;
        cyc(40);
        chk(CFG0.vout, 16'h03E8);
        load(1);
        chk(DEV_ADDR, 16'h0021);
        chk(CFG0.vout, 16'h0400);
        chk(CFG0.sync_drive, 16'h0000);
        @(posedge CLK);
        PIN_OPEN <= 6'h02;
        GLOBAL_CFG <= 8'h01 << `IGNORE_PINS_BIT;
        load(2);
        chk(DEV_ADDR, 16'h0023);
        chk(CFG0.vout, 16'h0400);
        chk(CFG1.vout, 16'h0500);
        @(posedge CLK);
        BUS_WDATA <= 16'h0777;
        {BUS_WR_VOUT0, BUS_WR_VOUT1, BUS_WR_RATE} <= 3'h7;
        @(posedge CLK);
        {BUS_WR_VOUT0, BUS_WR_VOUT1, BUS_WR_RATE} <= 3'h0;
        LOAD_SLOPE <= {16'h0000, 16'h0010};
        cyc(4);
        chk(CFG0.vout, 16'h0777);
        chk(CFG1.vout, 16'h0777);
        chk(CFG1.rate, 16'h0007);
        chk({SERVO_EN1, SERVO_EN0}, 16'h0002);
        memop(1'b0);
        @(posedge CLK);
        DIE_TEMP <= 16'sh0083;
        cyc(3);
        memop(1'b1);
        @(posedge CLK);
        DIE_TEMP <= 16'sh007F;
        cyc(3);
        memop(1'b1);
        @(posedge CLK);
        DIE_TEMP <= 16'sh007C;
        cyc(3);
        memop(1'b0);
        @(posedge CLK);
        {UV_CMP, UV_WARN_MON, START_DONE, FALLING, OV_CMP} <= 10'h3F9;
        PROTOCOL0 <= 1'b1;
        cyc(3);
        chk({UV_FAULT, UV_WARN}, 16'h0000);
        chk({TOP_OFF, BOT_ON}, 16'h0005);
        @(posedge CLK);
        CH_ON <= 2'h3;
        REV_OC <= 2'h1;
        {VIN_UV_MON, VIN_OV_MON} <= 2'h3;
        cyc(5);
        chk({UV_FAULT, UV_WARN}, 16'h0005);
        chk(BOT_ON, 16'h0000);
        chk({VIN_UV, VIN_OV}, 16'h0000);
        @(posedge CLK);
        MON_VALID <= 1'b1;
        OC_HIT <= 2'h1;
        @(posedge CLK);
        MON_VALID <= 1'b0;
        cyc(5);
        chk({VIN_UV, VIN_OV}, 16'h0003);
        chk({UV_FAULT, UV_WARN}, 16'h0000);
        @(posedge CLK);
        spoil <= 1'b1;
        load(1);
        chk({CML_STATUS, CRC_ERR_FLAG, ALERT_N, RUN_FORCE_LOW}, 16'h001B);
        am(7'h7C, 1'b1);
        am(7'h23, 1'b0);
        am(7'h5A, 1'b1);
        final_report();
    end
endmodule : test_cfg_fault_supervisor
`default_nettype wire
